// file: tb/ext_party.sv
// Purpose: crystal and wake-up source beside the controller
// Assumes: crystal modelled at half the clock rate
// Notes:   crystal stands still while the controller stops it
`timescale 1ns/10ps
module ext_party #(
	parameter int WAKE_HOLD = 20   // low time covering oscillator settling
) (
	input  wire logic clk,
	input  wire logic osc_enable,
	input  wire logic wake_req,
	output logic      osc_input_pin,
	output logic      wake_pin
);
	int hold;   // wake cycles still to hold low
	initial begin
		osc_input_pin = 1'b0;
		wake_pin = 1'b1;
		hold = 0;
	end
	// no duty cycle promised, so levels flip on every rising clock edge while osc_enable is high
	always @(posedge clk) begin
		if (osc_enable) osc_input_pin <= !osc_input_pin;
		if (wake_req) hold <= WAKE_HOLD;
		else if (hold > 0) hold <= hold - 1;
		wake_pin <= !(wake_req || hold > 1);
	end
endmodule : ext_party

// file: tb/pwr_monitor.sv
// Purpose: port-level checks of the power mode controller
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   attached to every controller instance by bind
`timescale 1ns/10ps
module pwr_monitor
	import pwr_mode_pkg::*;
(
	input wire logic                     clk,
	input wire logic                     reset,
	input wire logic                     reset_pin,
	input wire logic                     idle_req,
	input wire logic                     pdown_req,
	input wire logic                     instr_done,
	input wire logic                     irq_pending,
	input wire logic                     ext_irq_zero_pin,
	input wire pwr_mode_pkg::pin_out_t   pins,
	input wire logic                     osc_enable,
	input wire logic                     cpu_run,
	input wire logic                     ram_block,
	input wire logic                     sfr_reset,
	input wire logic                     emul_active,
	input wire logic [2:0]               mode_state
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// request taken in run mode, with and without power-down beside it
	sequence s_take_idle; mode_state == 3'h0 && instr_done && idle_req && !pdown_req; endsequence
	sequence s_take_pd; mode_state == 3'h0 && instr_done && pdown_req && !reset_pin; endsequence
	property p_idle_enter; s_take_idle |=> mode_state == 3'h1 && !cpu_run; endproperty
	a_idle_enter: assert property (p_idle_enter) else $error("idle not entered");
	property p_pd_enter; s_take_pd |=> mode_state == 3'h2; endproperty
	a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");
	property p_idle_pins; mode_state == 3'h1 |-> pins.addr_strobe && pins.fetch_strobe; endproperty
	a_idle_pins: assert property (p_idle_pins) else $error("idle strobes wrong");
	property p_pd_pins;
		mode_state == 3'h2 |-> !pins.addr_strobe && !pins.fetch_strobe && !cpu_run
			&& ($past(reset_pin) || !osc_enable);
	endproperty
	a_pd_pins: assert property (p_pd_pins) else $error("power-down pins wrong");
	property p_idle_exit; mode_state == 3'h1 && irq_pending |-> ##[1:3] mode_state == 3'h0; endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle kept on interrupt");
	property p_restart; mode_state == 3'h2 && !ext_irq_zero_pin |-> ##[1:3] osc_enable; endproperty
	a_restart: assert property (p_restart) else $error("oscillator not restarted");
	property p_wake_hold;
		mode_state == 3'h3 && !ext_irq_zero_pin && !reset_pin |=> mode_state == 3'h3;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake done while pin low");
	property p_runon; ram_block == (mode_state == 3'h4); endproperty
	a_runon: assert property (p_runon) else $error("ram block outside run-on");
	property p_rst_qual; $rose(sfr_reset) |-> $past(reset_pin) && $past(reset_pin, 8); endproperty
	a_rst_qual: assert property (p_rst_qual) else $error("reset taken too early");
	property p_emul_pins;
		emul_active |-> pins.weak_pullup && pins.low_port_oe_n == PORT_ALL_ONES && osc_enable;
	endproperty
	a_emul_pins: assert property (p_emul_pins) else $error("emulation pins wrong");
	property p_emul_hold; emul_active && !reset_pin && !$past(reset_pin) |=> emul_active; endproperty
	a_emul_hold: assert property (p_emul_hold) else $error("emulation left");
endmodule : pwr_monitor

bind power_mode_and_emulation_control pwr_monitor u_mon (.clk(clk), .reset(reset),
	.reset_pin(reset_pin), .idle_req(idle_req), .pdown_req(pdown_req),
	.instr_done(instr_done), .irq_pending(irq_pending), .ext_irq_zero_pin(ext_irq_zero_pin),
	.pins(pins), .osc_enable(osc_enable), .cpu_run(cpu_run), .ram_block(ram_block),
	.sfr_reset(sfr_reset), .emul_active(emul_active), .mode_state(mode_state));

// file: tb/tb_top.sv
// Purpose: random and corner runs of the power mode controller
// Assumes: 40 MHz clock, reset held ten cycles
// Notes:   expectations come from bench functions
`timescale 1ns/10ps
module tb_top;
	import pwr_mode_pkg::*;
	logic       clk, reset, osc_in, reset_pin, idle_req, pdown_req, instr_done, irq_pending;
	logic       wake_pin, wake_req, tie_hi, ext_mem, strap_n, osc_enable, cpu_run, ram_block;
	logic       sfr_reset, emul_active, i, p;
	logic       osc_out, phase_en;
	logic [7:0] n_ph;
	logic [2:0] mode_state, m;
	logic [31:0] r;
	core_pins_t cp;
	pin_out_t   pins;
	int         seed = 32'hf2c6, n_fail = 0, n_tests = 0, cycles = 0, k;

	power_mode_and_emulation_control dut (.clk(clk), .reset(reset), .osc_input_pin(osc_in),
		.reset_pin(reset_pin), .idle_req(idle_req), .pdown_req(pdown_req),
		.instr_done(instr_done), .irq_pending(irq_pending), .ext_irq_zero_pin(wake_pin),
		.ext_irq_one_pin(tie_hi), .ext_irq_zero_level_en(tie_hi), .ext_irq_one_level_en(tie_hi),
		.ext_program_mem(ext_mem), .addr_strobe_pin_in(strap_n), .program_fetch_strobe_in(tie_hi),
		.core_pins(cp), .pins(pins), .osc_output_pin(osc_out), .osc_enable(osc_enable),
		.phase_en(phase_en),
		.cpu_run(cpu_run), .ram_block(ram_block), .sfr_reset(sfr_reset),
		.emul_active(emul_active), .mode_state(mode_state));
	ext_party far (.clk(clk), .osc_enable(osc_enable), .wake_req(wake_req),
		.osc_input_pin(osc_in), .wake_pin(wake_pin));

	function automatic logic [2:0] exp_mode(input logic iq, input logic pq);
		return pq ? 3'h2 : (iq ? 3'h1 : 3'h0);   // power-down wins
	endfunction : exp_mode
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// bounded wait for a mode, or for the qualified reset when rst is set
	task automatic wait_on(input logic rst, input logic [2:0] mw);
		for (int j = 0; j < 300 && (rst ? sfr_reset !== 1'b1 : mode_state !== mw); j++) begin
			@(posedge clk);
			#1;
		end
		chk("wait", 8'h01, {7'h0, rst ? sfr_reset === 1'b1 : mode_state === mw});
	endtask : wait_on
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic req(input logic iq, input logic pq);
		@(posedge clk);
		{idle_req, pdown_req, instr_done} <= {iq, pq, 1'b1};
		@(posedge clk);
		instr_done <= 1'b0;
		#1;
	endtask : req

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// hang guard, far above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	initial begin
		{reset, tie_hi, strap_n} = 3'b111;
		{reset_pin, idle_req, pdown_req, instr_done, irq_pending, wake_req, ext_mem} = 7'h00;
		cp = '0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		for (k = 0; k < 16; k++) begin
			r = $random(seed);
			{p, i} = r[29:28];
			if (!p) i = 1'b1;
			@(posedge clk);
			cp <= core_pins_t'(r[26:0]); // pins settle before, never right after idle
			ext_mem <= r[27];
			req(i, p);
			m = exp_mode(i, p);
			chk("mode", {5'h0, m}, {5'h0, mode_state});
			chk("strobes", {6'h0, {2{m == 3'h1}}}, {6'h0, pins.addr_strobe, pins.fetch_strobe});
			chk("cpu run", 8'h0, {7'h0, cpu_run});
			if (ext_mem) chk("low port float", 8'hFF, pins.low_port_oe_n);
			if (ext_mem && !p) chk("high address", cp.high_addr, pins.high_port);
			if (p) begin
				@(posedge clk);
				#1;
				chk("osc output held", 8'h01, {7'h0, osc_out});
				wake_req <= 1'b1;
				@(posedge clk);
				wake_req <= 1'b0;
				wait_on(1'b0, 3'h3);
				chk("osc restart", 8'h01, {7'h0, osc_enable});
				chk("registers kept", 8'h00, {7'h0, sfr_reset});
				wait_on(1'b0, 3'h0);
				chk("wake pin high", 8'h01, {7'h0, wake_pin});
			end else if (r[30]) begin
				irq_pending <= 1'b1;
				wait_on(1'b0, 3'h0);
				irq_pending <= 1'b0;
			end else begin
				reset_pin <= 1'b1;
				repeat (3) @(posedge clk);
				#1;
				chk("run-on", 8'h14, {3'h0, ram_block, 1'b0, mode_state});
				chk("early reset", 8'h0, {7'h0, sfr_reset});
				wait_on(1'b1, 3'h0);
				reset_pin <= 1'b0;
				wait_on(1'b0, 3'h0);
			end
			chk("back in run", 8'h0, {5'h0, mode_state});
		end
		// power-down left by a qualified reset instead of a wake pin
		req(1'b0, 1'b1);
		reset_pin <= 1'b1;
		wait_on(1'b1, 3'h0);
		chk("reset leaves power-down", 8'h00, {5'h0, mode_state});
		chk("register reset", 8'h01, {7'h0, sfr_reset});
		reset_pin <= 1'b0;
		// emulation strap during reset, then a refused idle request
		// the wait lets the last qualified reset drain before the strap
		repeat (3) @(posedge clk);
		{reset_pin, strap_n} <= 2'b10;
		wait_on(1'b1, 3'h0);
		reset_pin <= 1'b0;
		repeat (3) @(posedge clk);
		strap_n <= 1'b1;
		req(1'b1, 1'b0);
		chk("emulation", 8'h15, {3'h0, emul_active, 1'b0, mode_state});
		chk("emul pins", 8'h03, {6'h0, pins.weak_pullup, osc_enable});
		// crystal toggles every clock, so one divided phase every two clocks
		n_ph = 8'h00;
		repeat (24) begin
			@(posedge clk);
			#1;
			n_ph = n_ph + {7'h0, phase_en};
		end
		chk("divided phases", 8'h0C, n_ph);
		reset_pin <= 1'b1;
		wait_on(1'b1, 3'h0);
		reset_pin <= 1'b0;
		wait_on(1'b0, 3'h0);
		chk("emulation left", 8'h0, {7'h0, emul_active});
		give_verdict();
	end
endmodule : tb_top

// file: verilog/power_mode_and_emulation_control.sv
// Purpose: idle, power-down and emulation mode control with pin steering
// Assumes: pins synchronous to clk; osc_input_pin is sampled, divided by two
// Notes:   processor core, RAM and register file live outside this block
`timescale 1ns/10ps

// Contract
// - idle: stop execution, keep registers and RAM
// - leave idle on reset or enabled interrupt
// - idle strobes high, low port floats externally
// - power-down strobes low, low port floats externally
// - power-down stops oscillator, no further instruction
// - power-down preserves RAM and registers
// - reset exit clears registers, keeps RAM
// - interrupt exit keeps registers and RAM
// - wake interrupts enabled and level-sensitive beforehand
// - low pin restarts oscillator, high completes exit
// - resume after power-down instruction via return
// - idle reset exit may run two cycles
// - block internal RAM during that run-on
// - emulation: float low port, weak pull-ups
// - emulation keeps oscillator running
// - emulation ends only on ordinary reset
// - oscillator input divided by two flip-flop
// - reset valid after two machine cycles held
module power_mode_and_emulation_control
	import pwr_mode_pkg::*;
#(
	parameter int PORT_WIDTH = PORT_W   // port width, documented as eight
) (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic                   osc_input_pin,
	input  wire logic                   reset_pin,
	input  wire logic                   idle_req,
	input  wire logic                   pdown_req,
	input  wire logic                   instr_done,
	input  wire logic                   irq_pending,
	input  wire logic                   ext_irq_zero_pin,
	input  wire logic                   ext_irq_one_pin,
	input  wire logic                   ext_irq_zero_level_en,
	input  wire logic                   ext_irq_one_level_en,
	input  wire logic                   ext_program_mem,
	input  wire logic                   addr_strobe_pin_in,
	input  wire logic                   program_fetch_strobe_in,
	input  wire pwr_mode_pkg::core_pins_t core_pins,
	output pwr_mode_pkg::pin_out_t      pins,
	output logic                        osc_output_pin,
	output logic                        osc_enable,
	output logic                        phase_en,
	output logic                        cpu_run,
	output logic                        ram_block,
	output logic                        sfr_reset,
	output logic                        emul_active,
	output logic [2:0]                  mode_state
);
	import pwr_mode_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	mode_t                 mode, next_mode;              // operating mode
	logic                  osc_q, next_osc_q;            // sampled oscillator input
	logic                  div2, next_div2;              // divide-by-two stage
	logic [MC_CNT_W-1:0]   phase_cnt, next_phase_cnt;    // phases within a machine cycle
	logic [RST_CNT_W-1:0]  rst_cnt, next_rst_cnt;        // reset qualification count
	logic [RST_CNT_W-1:0]  runon_cnt, next_runon_cnt;    // idle run-on count
	logic                  rst_valid, next_rst_valid;    // qualified hardware reset
	logic                  emul_req, next_emul_req;      // emulation request seen in reset
	logic                  osc_run;                      // oscillator gate this cycle
	logic                  mcycle_end;                   // last phase of a machine cycle
	logic                  wake_low;                     // a wake pin held low
	pin_out_t              next_pins;                    // pin values to register
	logic                  next_cpu_run, next_ram_block, next_sfr_reset;
	logic                  next_osc_en;                  // oscillator enable one cycle ahead

	// oscillator runs in every mode except power-down with no wake pin low;
	// a held reset pin restarts it too, else reset could never qualify there
	assign wake_low = (~ext_irq_zero_pin & ext_irq_zero_level_en)
		| (~ext_irq_one_pin & ext_irq_one_level_en);
	assign osc_run  = (mode != MODE_PDOWN) || wake_low || reset_pin;
	// one strobe per machine cycle, taken from the registered phase pulse
	assign mcycle_end = phase_en && (phase_cnt == PHASE_LAST);

	// ----------------------------------------------------------------
	// clock divider and machine cycle timing
	// ----------------------------------------------------------------
	// rising edge of the sampled input toggles the divider; duty cycle is irrelevant
	always_comb begin
		next_osc_q     = osc_input_pin;
		next_div2      = div2;
		next_phase_cnt = phase_cnt;
		if (osc_run && osc_input_pin && !osc_q) begin
			next_div2 = ~div2;
			if (phase_cnt == PHASE_LAST) begin
				next_phase_cnt = '0;
			end else begin
				next_phase_cnt = phase_cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			osc_q     <= 1'b0;
			div2      <= 1'b0;
			phase_cnt <= '0;
		end else begin
			osc_q     <= next_osc_q;
			div2      <= next_div2;
			phase_cnt <= next_phase_cnt;
		end
	end

	// ----------------------------------------------------------------
	// reset qualification and emulation request capture
	// ----------------------------------------------------------------
	// reset counts only machine cycles, so a stopped oscillator never qualifies it
	always_comb begin
		next_rst_cnt   = rst_cnt;
		next_rst_valid = rst_valid;
		next_emul_req  = emul_req;
		if (!reset_pin) begin
			next_rst_cnt   = '0;
			next_rst_valid = 1'b0;
		end else if (mcycle_end && rst_cnt != RST_HOLD_COUNT) begin
			next_rst_cnt = rst_cnt + 4'h1;
		end else if (rst_cnt == RST_HOLD_COUNT) begin
			next_rst_valid = 1'b1;
		end
		// emulation request follows the strap while a valid reset is held
		if (rst_valid && reset_pin) begin
			next_emul_req = !addr_strobe_pin_in && program_fetch_strobe_in;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rst_cnt   <= '0;
			rst_valid <= 1'b0;
			emul_req  <= 1'b0;
		end else begin
			rst_cnt   <= next_rst_cnt;
			rst_valid <= next_rst_valid;
			emul_req  <= next_emul_req;
		end
	end

	// ----------------------------------------------------------------
	// mode sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_mode      = mode;
		next_runon_cnt = runon_cnt;
		unique case (mode)
			MODE_RUN: begin
				// power-down wins if both bits are written together
				if (instr_done && pdown_req) begin
					next_mode = MODE_PDOWN;
				end else if (instr_done && idle_req) begin
					next_mode = MODE_IDLE;
				end
			end
			MODE_IDLE: begin
				if (reset_pin) begin
					next_mode      = MODE_RUNON;
					next_runon_cnt = '0;
				end else if (irq_pending) begin
					next_mode = MODE_RUN;
				end
			end
			MODE_RUNON: begin
				// limited execution until reset qualifies or the window closes
				if (mcycle_end && runon_cnt != RUNON_COUNT) begin
					next_runon_cnt = runon_cnt + 4'h1;
				end
				if (!reset_pin) begin
					next_mode = MODE_RUN;
				end
			end
			MODE_PDOWN: begin
				// a held reset pin is handled by the override below
				if (wake_low) begin
					next_mode = MODE_WAKE;
				end
			end
			MODE_WAKE: begin
				// exit completes only once every wake pin is back high
				if (!wake_low) begin
					next_mode = MODE_RUN;
				end
			end
			MODE_EMUL: begin
				// strap and request inputs are ignored until a qualified reset
				next_mode = MODE_EMUL;
			end
			default: begin
				next_mode = MODE_RUN;
			end
		endcase
		// qualified reset overrides every mode; strap decides emulation on release
		if (rst_valid) begin
			next_mode = MODE_RUN;
			if (!reset_pin && emul_req && !addr_strobe_pin_in) begin
				next_mode = MODE_EMUL;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode      <= MODE_RUN;
			runon_cnt <= '0;
		end else begin
			mode      <= next_mode;
			runon_cnt <= next_runon_cnt;
		end
	end

	// ----------------------------------------------------------------
	// pin steering and core controls
	// ----------------------------------------------------------------
	// ports keep latched data; strobes and the low port change per mode, the high port too in idle and emulation
	always_comb begin
		next_pins.addr_strobe       = core_pins.addr_strobe;
		next_pins.addr_strobe_oe_n  = 1'b0;
		next_pins.fetch_strobe      = core_pins.fetch_strobe;
		next_pins.fetch_strobe_oe_n = 1'b0;
		next_pins.low_port          = core_pins.low_port;
		next_pins.low_port_oe_n     = core_pins.low_port_drive ? '0 : PORT_ALL_ONES;
		next_pins.high_port         = core_pins.high_port;
		next_pins.high_port_oe_n    = '0;
		next_pins.weak_pullup       = 1'b0;
		// controls except sfr_reset follow the next mode, so they move together with mode_state
		next_cpu_run   = (next_mode == MODE_RUN)
			|| (next_mode == MODE_RUNON && next_runon_cnt != RUNON_COUNT);
		next_ram_block = (next_mode == MODE_RUNON);
		next_sfr_reset = rst_valid;
		next_osc_en    = (next_mode != MODE_PDOWN) || wake_low || reset_pin;
		unique case (next_mode)
			MODE_IDLE: begin
				next_pins.addr_strobe  = STROBE_IDLE_LEVEL;
				next_pins.fetch_strobe = STROBE_IDLE_LEVEL;
				if (ext_program_mem) begin
					next_pins.low_port_oe_n = PORT_ALL_ONES;
					next_pins.high_port     = core_pins.high_addr;
				end
			end
			MODE_PDOWN, MODE_WAKE: begin
				// register file and RAM simply see no clock or writes here
				next_pins.addr_strobe  = STROBE_PD_LEVEL;
				next_pins.fetch_strobe = STROBE_PD_LEVEL;
				if (ext_program_mem) begin
					next_pins.low_port_oe_n = PORT_ALL_ONES;
				end
			end
			MODE_EMUL: begin
				// released strobes and ports idle high through weak pull-ups
				next_pins.addr_strobe       = 1'b1;
				next_pins.addr_strobe_oe_n  = 1'b1;
				next_pins.fetch_strobe      = 1'b1;
				next_pins.fetch_strobe_oe_n = 1'b1;
				next_pins.low_port_oe_n     = PORT_ALL_ONES;
				next_pins.high_port         = PORT_ALL_ONES;
				next_pins.high_port_oe_n    = PORT_ALL_ONES;
				next_pins.weak_pullup       = 1'b1;
			end
			default: begin
			end
		endcase
	end

	// every output is registered; mode and controls take next-cycle values, sfr_reset follows rst_valid a cycle later
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pins           <= '0;
			osc_output_pin <= 1'b1;
			osc_enable     <= 1'b1;
			phase_en       <= 1'b0;
			cpu_run        <= 1'b0;
			ram_block      <= 1'b0;
			sfr_reset      <= 1'b0;
			emul_active    <= 1'b0;
			mode_state     <= 3'h0;
		end else begin
			pins           <= next_pins;
			osc_output_pin <= ~(osc_input_pin & osc_run);                  // inverting amplifier
			osc_enable     <= next_osc_en;
			phase_en       <= next_div2 ^ div2;                            // one pulse per toggle
			cpu_run        <= next_cpu_run;
			ram_block      <= next_ram_block;
			sfr_reset      <= next_sfr_reset;
			emul_active    <= (next_mode == MODE_EMUL);
			mode_state     <= next_mode;
		end
	end

endmodule : power_mode_and_emulation_control

// file: verilog/pwr_mode_pkg.sv
// Purpose: shared constants and types for the power mode and emulation controller
// Assumes: one 40 MHz clock, active-high asynchronous reset
// Notes:   a machine cycle is six oscillator periods, six phase enables
package pwr_mode_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int PHASES_PER_MCYCLE   = 6;   // divided-clock phases per machine cycle
	localparam int RESET_MCYCLES       = 2;   // reset must be held this many machine cycles
	localparam int IDLE_RUNON_MCYCLES  = 2;   // execution allowed before reset takes over
	localparam int MC_CNT_W            = 3;   // width of phase counter
	localparam int RST_CNT_W           = 4;   // width of reset qualification counter

	localparam logic [MC_CNT_W-1:0]  PHASE_LAST     = 3'h5;
	localparam logic [RST_CNT_W-1:0] RST_HOLD_COUNT = 4'h2;
	localparam logic [RST_CNT_W-1:0] RUNON_COUNT    = 4'h2;

	// ----------------------------------------------------------------
	// pin levels and port width
	// ----------------------------------------------------------------
	localparam int PORT_W = 8;
	localparam logic STROBE_IDLE_LEVEL = 1'h1;   // strobes held high in idle
	localparam logic STROBE_PD_LEVEL   = 1'h0;   // strobes held low in power-down
	localparam logic [PORT_W-1:0] PORT_ALL_ONES = 8'hFF;

	// ----------------------------------------------------------------
	// operating modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_RUN   = 3'b000,
		MODE_IDLE  = 3'b001,
		MODE_PDOWN = 3'b010,
		MODE_WAKE  = 3'b011,
		MODE_RUNON = 3'b100,
		MODE_EMUL  = 3'b101
	} mode_t;

	// normal-run pin values presented by the core
	typedef struct packed {
		logic              addr_strobe;
		logic              fetch_strobe;
		logic [PORT_W-1:0] low_port;
		logic              low_port_drive;
		logic [PORT_W-1:0] high_port;
		logic [PORT_W-1:0] high_addr;
	} core_pins_t;

	// pin values driven by the block
	typedef struct packed {
		logic              addr_strobe;
		logic              addr_strobe_oe_n;
		logic              fetch_strobe;
		logic              fetch_strobe_oe_n;
		logic [PORT_W-1:0] low_port;
		logic [PORT_W-1:0] low_port_oe_n;
		logic [PORT_W-1:0] high_port;
		logic [PORT_W-1:0] high_port_oe_n;
		logic              weak_pullup;
	} pin_out_t;

endpackage : pwr_mode_pkg
